// >>> shared/pmw_pkg.sv
// pmw_pkg: constants and types for the power mode and wake controller.
// assumes one always-on clock at CLK_HZ; byte offsets.
package pmw_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock rate and sequencing times
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
    // least times, rounded up to whole cycles
    localparam int unsigned POR_SETTLE_NS = 4000;
    localparam int unsigned POR_CYCLES = (POR_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned OSC_SETTLE_NS = 2000;
    localparam int unsigned OSC_CYCLES = (OSC_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RST_HOLD_NS = 400;
    localparam int unsigned RST_HOLD_CYCLES = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned ENTRY_NS = 400;
    localparam int unsigned ENTRY_CYCLES = (ENTRY_NS * CLK_MHZ + 999) / 1000;
    // charge pacing: period rounded up, on-time down
    localparam int unsigned CHARGE_PERIOD_NS = 1280;
    localparam int unsigned CHARGE_PERIOD_CYCLES = (CHARGE_PERIOD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CHARGE_ON_NS = 320;
    localparam int unsigned CHARGE_ON_CYCLES = (CHARGE_ON_NS * CLK_MHZ) / 1000;
    localparam int unsigned SEQ_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WAKE = 8'h04;
    localparam logic [7:0] ADDR_TLOAD = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_RTC = 8'h10;
    localparam logic [7:0] ADDR_TCNT = 8'h14;

    // field positions
    localparam int unsigned CTRL_SAVE_BIT = 0;
    localparam int unsigned CTRL_NVM_BIT = 1;
    localparam int unsigned CTRL_DIV_LSB = 4;
    localparam int unsigned DIV_W = 4;
    localparam int unsigned WAKE_NFC_BIT = 0;
    localparam int unsigned WAKE_PIN_BIT = 1;
    localparam int unsigned WAKE_POL_BIT = 2;
    localparam int unsigned WAKE_TMR_BIT = 3;
    localparam int unsigned STAT_CAUSE_LSB = 0;
    localparam int unsigned STAT_SUPPLY_BIT = 4;
    localparam int unsigned STAT_FIELD_BIT = 5;
    localparam int unsigned STAT_SLEEP_BIT = 6;
    localparam int unsigned STAT_STATE_LSB = 8;
    localparam int unsigned TMR_W = 16;

    // values after reset
    localparam logic CTRL_NVM_RST = 1'b1;
    localparam logic [3:0] CTRL_DIV_RST = 4'h0;
    localparam logic [3:0] WAKE_RST = 4'h0;
    localparam logic [15:0] TLOAD_RST = 16'h0000;

    // controller states, gray from ST_POR through ST_WAKE; ST_WAKE to ST_RELEASE changes two bits
    typedef enum logic [2:0] {
        ST_POR = 3'b000,
        ST_DETECT = 3'b001,
        ST_OSC = 3'b011,
        ST_RELEASE = 3'b010,
        ST_OPER = 3'b110,
        ST_ENTRY = 3'b111,
        ST_SAVE = 3'b101,
        ST_WAKE = 3'b100
    } pmw_state_type;

endpackage : pmw_pkg

// >>> src/pmw_sync.sv
// pmw_sync: two-flop synchroniser for a vector of independent levels.
// assumes each bit is a slow level; no word coherence across bits.
`timescale 1ns/1ps
`default_nettype none
module pmw_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule : pmw_sync
`default_nettype wire

// >>> src/pmw_top.sv
// pmw_top: always-on power mode, wake and clock gating controller.
// assumes MCLK_I is always on; pins unsynchronised.
//
// Behaviour
// - power-up ends in operation mode
// - software request performs full power save entry
// - enabled field presence wakes from save
// - enabled wake pin level wakes, polarity programmable
// - enabled standby timer wakes after programmed ticks
// - standby timer counts only once save entered
// - save keeps standby on, others off except nfc while field present
// - operation nvm power follows software, default on
// - nfc domain powered exactly while field present
// - fast oscillator off in save, on operating
// - fast clock divider ratio programmable
// - slow oscillator never off, clocks controller
// - start-up, entry and wake sequenced here
// - wait instructions enter sleep, interrupt ends it
// - sleep gates cpu clock only, peripheral clock kept
// - supply pin presence selects start-up mode
// - field-powered mode charges bridge capacitor paced
// - wake timer and rtc run through save
// - carrier clock enabled only with field present
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pmw_top #(
    parameter int RTC_W = 32
) (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    // wishbone classic slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // pins and core status, asynchronous
    input wire logic SUPPLY_DETECT_I,
    input wire logic FIELD_PRESENT_I,
    input wire logic WAKE_PIN_I,
    input wire logic WAIT_INTERRUPT_INSTRUCTION_I,
    input wire logic WAIT_EVENT_INSTRUCTION_I,
    input wire logic IRQ_PENDING_I,
    input wire logic BRIDGE_SUPPLY_PIN_FULL_I,
    // power and clock controls
    output logic STBY_PWR_EN_O,
    output logic CORE_PWR_EN_O,
    output logic IO_PWR_EN_O,
    output logic NVM_PWR_EN_O,
    output logic HB_PWR_EN_O,
    output logic NFC_PWR_EN_O,
    output logic MAIN_OSC_EN_O,
    output logic SLOW_OSC_EN_O,
    output logic CORE_RST_N_O,
    output logic CPU_CLK_EN_O,
    output logic PERIPH_CLK_EN_O,
    output logic [3:0] FAST_DIV_O,
    output logic CARRIER_CLK_EN_O,
    output logic BRIDGE_CHARGE_O,
    output logic SUPPLY_ACTIVE_O,
    output logic POWER_SAVE_O
);

    ////////////////////////////////////////////////////////////////////////////
    // synchronised inputs
    logic [6:0] pins_s;
    logic supply_s;
    logic field_s;
    logic wake_pin_s;
    logic wfi_s;
    logic wfe_s;
    logic irq_s;
    logic bridge_full_s;

    pmw_sync #(
        .WIDTH(7)
    ) u_sync (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .d_i({BRIDGE_SUPPLY_PIN_FULL_I, IRQ_PENDING_I, WAIT_EVENT_INSTRUCTION_I,
            WAIT_INTERRUPT_INSTRUCTION_I, WAKE_PIN_I, FIELD_PRESENT_I, SUPPLY_DETECT_I}),
        .q_o(pins_s)
    );

    assign supply_s = pins_s[0];
    assign field_s = pins_s[1];
    assign wake_pin_s = pins_s[2];
    assign wfi_s = pins_s[3];
    assign wfe_s = pins_s[4];
    assign irq_s = pins_s[5];
    assign bridge_full_s = pins_s[6];

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    pmw_pkg::pmw_state_type state;
    pmw_pkg::pmw_state_type next_state;
    logic [pmw_pkg::SEQ_W-1:0] seq_cnt;
    logic seq_done;
    logic supply_active;
    logic save_req;
    logic nvm_en;
    logic [3:0] div_ratio;
    logic [3:0] wake_cfg;
    logic [pmw_pkg::TMR_W-1:0] tmr_load;
    logic [pmw_pkg::TMR_W-1:0] tmr_cnt;
    logic [2:0] wake_cause;
    logic [RTC_W-1:0] rtc_cnt;
    logic sleep;
    logic wfi_d;
    logic wfe_d;
    logic [pmw_pkg::SEQ_W-1:0] chg_cnt;
    logic bus_req;
    logic wr_en;
    logic save_wr;
    logic pin_active;
    logic wake_nfc;
    logic wake_pin;
    logic wake_tmr;
    logic wake_any;
    logic dom_on;
    logic [31:0] rd_data;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr_en = bus_req && WB_WE_I && WB_SEL_I[0];
    assign save_wr = wr_en && (WB_ADR_I == pmw_pkg::ADDR_CTRL) && WB_DAT_I[pmw_pkg::CTRL_SAVE_BIT];

    // one ack per request
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= bus_req;
        end
    end

    // read mux, unmapped read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (WB_ADR_I)
            pmw_pkg::ADDR_CTRL: begin
                rd_data[pmw_pkg::CTRL_SAVE_BIT] = save_req;
                rd_data[pmw_pkg::CTRL_NVM_BIT] = nvm_en;
                rd_data[pmw_pkg::CTRL_DIV_LSB +: pmw_pkg::DIV_W] = div_ratio;
            end
            pmw_pkg::ADDR_WAKE: rd_data[3:0] = wake_cfg;
            pmw_pkg::ADDR_TLOAD: rd_data[pmw_pkg::TMR_W-1:0] = tmr_load;
            pmw_pkg::ADDR_STAT: begin
                rd_data[pmw_pkg::STAT_CAUSE_LSB +: 3] = wake_cause;
                rd_data[pmw_pkg::STAT_SUPPLY_BIT] = supply_active;
                rd_data[pmw_pkg::STAT_FIELD_BIT] = field_s;
                rd_data[pmw_pkg::STAT_SLEEP_BIT] = sleep;
                rd_data[pmw_pkg::STAT_STATE_LSB +: 3] = state;
            end
            pmw_pkg::ADDR_RTC: rd_data[RTC_W-1:0] = rtc_cnt;
            pmw_pkg::ADDR_TCNT: rd_data[pmw_pkg::TMR_W-1:0] = tmr_cnt;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // read data registered with the ack
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (bus_req && !WB_WE_I) begin
            WB_DAT_O <= rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software configuration
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            nvm_en <= pmw_pkg::CTRL_NVM_RST;
            div_ratio <= pmw_pkg::CTRL_DIV_RST;
        end else if (wr_en && WB_ADR_I == pmw_pkg::ADDR_CTRL) begin
            nvm_en <= WB_DAT_I[pmw_pkg::CTRL_NVM_BIT];
            div_ratio <= WB_DAT_I[pmw_pkg::CTRL_DIV_LSB +: pmw_pkg::DIV_W];
        end
    end

    // wake enables and polarity
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            wake_cfg <= pmw_pkg::WAKE_RST;
        end else if (wr_en && WB_ADR_I == pmw_pkg::ADDR_WAKE) begin
            wake_cfg <= WB_DAT_I[3:0];
        end
    end

    // standby tick count, by byte lane
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            tmr_load <= pmw_pkg::TLOAD_RST;
        end else if (bus_req && WB_WE_I && WB_ADR_I == pmw_pkg::ADDR_TLOAD) begin
            if (WB_SEL_I[0]) begin
                tmr_load[7:0] <= WB_DAT_I[7:0];
            end
            if (WB_SEL_I[1]) begin
                tmr_load[15:8] <= WB_DAT_I[15:8];
            end
        end
    end

    // save request until taken
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            save_req <= 1'b0;
        end else if (save_wr && state == pmw_pkg::ST_OPER) begin
            save_req <= 1'b1;
        end else if (state != pmw_pkg::ST_OPER) begin
            save_req <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake conditions
    assign pin_active = wake_cfg[pmw_pkg::WAKE_POL_BIT] ? wake_pin_s : !wake_pin_s;
    assign wake_nfc = wake_cfg[pmw_pkg::WAKE_NFC_BIT] && field_s;
    assign wake_pin = wake_cfg[pmw_pkg::WAKE_PIN_BIT] && pin_active;
    assign wake_tmr = wake_cfg[pmw_pkg::WAKE_TMR_BIT] && (tmr_cnt == tmr_load);
    assign wake_any = state == pmw_pkg::ST_SAVE && (wake_nfc || wake_pin || wake_tmr);

    // standby timer, counts only in save
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            tmr_cnt <= '0;
        end else if (state == pmw_pkg::ST_ENTRY) begin
            tmr_cnt <= '0;
        end else if (state == pmw_pkg::ST_SAVE && tmr_cnt != tmr_load) begin
            tmr_cnt <= tmr_cnt + 16'h0001;
        end
    end

    // real time counter
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            rtc_cnt <= '0;
        end else begin
            rtc_cnt <= rtc_cnt + RTC_W'(1);
        end
    end

    // sticky wake cause, w1c, set wins
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            wake_cause <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wake_any && (i == 0 ? wake_nfc : (i == 1 ? wake_pin : wake_tmr))) begin
                    wake_cause[i] <= 1'b1;
                end else if (wr_en && WB_ADR_I == pmw_pkg::ADDR_STAT && WB_DAT_I[i]) begin
                    wake_cause[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        unique case (state)
            pmw_pkg::ST_POR: seq_done = seq_cnt == pmw_pkg::SEQ_W'(pmw_pkg::POR_CYCLES - 1);
            pmw_pkg::ST_OSC, pmw_pkg::ST_WAKE:
                seq_done = seq_cnt == pmw_pkg::SEQ_W'(pmw_pkg::OSC_CYCLES - 1);
            pmw_pkg::ST_RELEASE:
                seq_done = seq_cnt == pmw_pkg::SEQ_W'(pmw_pkg::RST_HOLD_CYCLES - 1);
            pmw_pkg::ST_ENTRY:
                seq_done = seq_cnt == pmw_pkg::SEQ_W'(pmw_pkg::ENTRY_CYCLES - 1);
            default: seq_done = 1'b1;
        endcase
    end

    // next state
    always_comb begin
        next_state = state;
        unique case (state)
            pmw_pkg::ST_POR: if (seq_done) next_state = pmw_pkg::ST_DETECT;
            pmw_pkg::ST_DETECT: next_state = pmw_pkg::ST_OSC;
            pmw_pkg::ST_OSC: if (seq_done) next_state = pmw_pkg::ST_RELEASE;
            pmw_pkg::ST_RELEASE: if (seq_done) next_state = pmw_pkg::ST_OPER;
            pmw_pkg::ST_OPER: if (save_req) next_state = pmw_pkg::ST_ENTRY;
            pmw_pkg::ST_ENTRY: if (seq_done) next_state = pmw_pkg::ST_SAVE;
            pmw_pkg::ST_SAVE: if (wake_any) next_state = pmw_pkg::ST_WAKE;
            pmw_pkg::ST_WAKE: if (seq_done) next_state = pmw_pkg::ST_RELEASE;
        endcase
    end

    // state and step counter
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            state <= pmw_pkg::ST_POR;
            seq_cnt <= '0;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                seq_cnt <= '0;
            end else if (!seq_done) begin
                seq_cnt <= seq_cnt + pmw_pkg::SEQ_W'(1);
            end
        end
    end

    // supply mode caught once per power-up
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            supply_active <= 1'b0;
        end else if (state == pmw_pkg::ST_DETECT) begin
            supply_active <= supply_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sleep on wait instructions
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            wfi_d <= 1'b0;
            wfe_d <= 1'b0;
            sleep <= 1'b0;
        end else begin
            wfi_d <= wfi_s;
            wfe_d <= wfe_s;
            if (state != pmw_pkg::ST_OPER || irq_s) begin
                sleep <= 1'b0;
            end else if ((wfi_s && !wfi_d) || (wfe_s && !wfe_d)) begin
                sleep <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bridge charge pacing
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            chg_cnt <= '0;
        end else if (chg_cnt == pmw_pkg::SEQ_W'(pmw_pkg::CHARGE_PERIOD_CYCLES - 1)) begin
            chg_cnt <= '0;
        end else begin
            chg_cnt <= chg_cnt + pmw_pkg::SEQ_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power and clock controls
    assign dom_on = state == pmw_pkg::ST_OSC || state == pmw_pkg::ST_RELEASE
        || state == pmw_pkg::ST_OPER || state == pmw_pkg::ST_ENTRY
        || state == pmw_pkg::ST_WAKE;

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            STBY_PWR_EN_O <= 1'b1;
            SLOW_OSC_EN_O <= 1'b1;
            CORE_PWR_EN_O <= 1'b0;
            IO_PWR_EN_O <= 1'b0;
            HB_PWR_EN_O <= 1'b0;
            NVM_PWR_EN_O <= 1'b0;
            MAIN_OSC_EN_O <= 1'b0;
            NFC_PWR_EN_O <= 1'b0;
            CARRIER_CLK_EN_O <= 1'b0;
            CORE_RST_N_O <= 1'b0;
            POWER_SAVE_O <= 1'b0;
        end else begin
            STBY_PWR_EN_O <= 1'b1;
            SLOW_OSC_EN_O <= 1'b1;
            CORE_PWR_EN_O <= dom_on;
            IO_PWR_EN_O <= dom_on;
            HB_PWR_EN_O <= dom_on;
            NVM_PWR_EN_O <= dom_on && nvm_en;
            MAIN_OSC_EN_O <= dom_on;
            NFC_PWR_EN_O <= field_s;
            CARRIER_CLK_EN_O <= field_s;
            CORE_RST_N_O <= state == pmw_pkg::ST_OPER;
            POWER_SAVE_O <= state == pmw_pkg::ST_SAVE;
        end
    end

    // clock gating, divider, supply mode, charge
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            CPU_CLK_EN_O <= 1'b0;
            PERIPH_CLK_EN_O <= 1'b0;
            FAST_DIV_O <= pmw_pkg::CTRL_DIV_RST;
            SUPPLY_ACTIVE_O <= 1'b0;
            BRIDGE_CHARGE_O <= 1'b0;
        end else begin
            CPU_CLK_EN_O <= state == pmw_pkg::ST_OPER && !sleep;
            PERIPH_CLK_EN_O <= state == pmw_pkg::ST_OPER;
            FAST_DIV_O <= div_ratio;
            SUPPLY_ACTIVE_O <= supply_active;
            BRIDGE_CHARGE_O <= !supply_active && field_s && !bridge_full_s && dom_on
                && chg_cnt < pmw_pkg::SEQ_W'(pmw_pkg::CHARGE_ON_CYCLES);
        end
    end

endmodule : pmw_top
`default_nettype wire

// >>> verif/pmw_top_props.sv
// pmw_top_props: port-level checks of the controller.
// assumes one clock, MCLK_I, and synchronous reset RST_N_I.
`timescale 1ns/1ps
`default_nettype none
module pmw_top_props (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic FIELD_PRESENT_I,
    input wire logic WAIT_INTERRUPT_INSTRUCTION_I,
    input wire logic IRQ_PENDING_I,
    input wire logic STBY_PWR_EN_O,
    input wire logic SLOW_OSC_EN_O,
    input wire logic CORE_PWR_EN_O,
    input wire logic IO_PWR_EN_O,
    input wire logic NVM_PWR_EN_O,
    input wire logic HB_PWR_EN_O,
    input wire logic NFC_PWR_EN_O,
    input wire logic MAIN_OSC_EN_O,
    input wire logic CORE_RST_N_O,
    input wire logic CPU_CLK_EN_O,
    input wire logic PERIPH_CLK_EN_O,
    input wire logic CARRIER_CLK_EN_O,
    input wire logic POWER_SAVE_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    ////////////////////////////////////////////////////////////////////////////
    // named steps
    sequence entry_start;
        $fell(CORE_RST_N_O);
    endsequence
    sequence wake_start;
        $fell(POWER_SAVE_O);
    endsequence
    sequence wait_seen;
        $rose(WAIT_INTERRUPT_INSTRUCTION_I) && CORE_RST_N_O && !IRQ_PENDING_I;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("no ack");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack too long");
    always_on_a: assert property (STBY_PWR_EN_O && SLOW_OSC_EN_O)
        else $error("always-on off");
    save_off_a: assert property (POWER_SAVE_O |-> !(CORE_PWR_EN_O || IO_PWR_EN_O ||
        NVM_PWR_EN_O || HB_PWR_EN_O || MAIN_OSC_EN_O)) else $error("domain on in save");
    nvm_gated_a: assert property (NVM_PWR_EN_O |-> CORE_PWR_EN_O)
        else $error("nvm on alone");
    field_power_a: assert property ((FIELD_PRESENT_I) [*5] |-> NFC_PWR_EN_O &&
        CARRIER_CLK_EN_O) else $error("nfc off with field");
    no_field_a: assert property ((!FIELD_PRESENT_I) [*5] |-> !NFC_PWR_EN_O &&
        !CARRIER_CLK_EN_O) else $error("nfc on, no field");
    release_ready_a: assert property (CORE_RST_N_O |-> MAIN_OSC_EN_O && CORE_PWR_EN_O &&
        IO_PWR_EN_O && HB_PWR_EN_O && PERIPH_CLK_EN_O) else $error("core unpowered");
    cpu_gate_a: assert property (CPU_CLK_EN_O |-> PERIPH_CLK_EN_O)
        else $error("cpu clock alone");
    entry_bound_a: assert property (entry_start |-> ##[8:12] POWER_SAVE_O)
        else $error("save late");
    wake_order_a: assert property (wake_start |-> (MAIN_OSC_EN_O && CORE_PWR_EN_O &&
        !CORE_RST_N_O) [*8]) else $error("wake release early");
    sleep_gate_a: assert property (wait_seen ##1 (!IRQ_PENDING_I) [*6] |-> !CPU_CLK_EN_O)
        else $error("cpu not gated");
endmodule : pmw_top_props
bind pmw_top pmw_top_props u_props (.*);
`default_nettype wire

// >>> verif/pmw_cpu_model.sv
// pmw_cpu_model: cpu side, a wishbone master and wait lines.
// assumes tasks start just after a rising clk_i edge.
`timescale 1ns/1ps
`default_nettype none
module pmw_cpu_model (
    input wire logic clk_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    input wire logic [31:0] dat_i,
    input wire logic ack_i,
    output logic wfi_o,
    output logic wfe_o,
    output logic irq_o
);
    logic hung;
    // idle master
    initial begin
        {cyc_o, stb_o, we_o, wfi_o, wfe_o, irq_o, hung, adr_o, sel_o, dat_o} = 51'h0;
    end
    // one classic cycle, held until ack
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n = 0;
        {cyc_o, stb_o} <= 2'b11;
        we_o <= we;
        adr_o <= adr;
        sel_o <= 4'hF;
        dat_o <= wd;
        @(posedge clk_i);
        while (ack_i !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        hung = (n >= 50);
        rd = dat_i;
        {cyc_o, stb_o} <= 2'b00;
        adr_o <= ~adr;
        dat_o <= ~wd;
        @(posedge clk_i);
    endtask : bus
    // wait instruction: k=0 interrupt, else event
    task automatic wait_instr(input int k);
        if (k == 0) wfi_o <= 1'b1;
        else wfe_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        {wfi_o, wfe_o} <= 2'b00;
    endtask : wait_instr
    task automatic irq(input logic v);
        irq_o <= v;
    endtask : irq
endmodule : pmw_cpu_model
`default_nettype wire

// >>> verif/pmw_top_test.sv
// pmw_top_test: self-checking bench for the controller.
// assumes the package is compiled first; 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module pmw_top_test;
    typedef struct packed {
        logic we;
        logic [7:0] adr;
        logic [31:0] wd;
        logic [31:0] ex;
    } pmw_row_type;
    pmw_row_type rows [9];
    logic MCLK_I = 1'b0;
    logic RST_N_I = 1'b0;
    logic SUPPLY_DETECT_I = 1'b1;
    logic FIELD_PRESENT_I = 1'b0;
    logic WAKE_PIN_I = 1'b1;
    logic BRIDGE_SUPPLY_PIN_FULL_I = 1'b0;
    wire cyc, stb, we, ack, wait_interrupt_instruction, wait_event_instruction, irq;
    wire [7:0] adr;
    wire [3:0] sel;
    wire [31:0] wdat, rdat;
    wire STBY, CORE, IO, NVM, HB, NFC, MOSC, SOSC, CRST, CPUCK, BCHG, SACT, SAVE;
    wire [3:0] FDIV;
    int bad_count = 0;
    int n_tests = 0;
    logic [31:0] rd;
    int n, k;
    always #20 MCLK_I = ~MCLK_I;
    pmw_cpu_model u_cpu (.clk_i(MCLK_I), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack), .wfi_o(wait_interrupt_instruction), .wfe_o(wait_event_instruction),
        .irq_o(irq));
    pmw_top u_dut (.MCLK_I, .RST_N_I, .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .SUPPLY_DETECT_I, .FIELD_PRESENT_I, .WAKE_PIN_I, .WAIT_INTERRUPT_INSTRUCTION_I(wait_interrupt_instruction),
        .WAIT_EVENT_INSTRUCTION_I(wait_event_instruction), .IRQ_PENDING_I(irq), .BRIDGE_SUPPLY_PIN_FULL_I,
        .STBY_PWR_EN_O(STBY), .CORE_PWR_EN_O(CORE), .IO_PWR_EN_O(IO), .NVM_PWR_EN_O(NVM),
        .HB_PWR_EN_O(HB), .NFC_PWR_EN_O(NFC), .MAIN_OSC_EN_O(MOSC), .SLOW_OSC_EN_O(SOSC),
        .CORE_RST_N_O(CRST), .CPU_CLK_EN_O(CPUCK), .PERIPH_CLK_EN_O(), .FAST_DIV_O(FDIV),
        .CARRIER_CLK_EN_O(), .BRIDGE_CHARGE_O(BCHG), .SUPPLY_ACTIVE_O(SACT),
        .POWER_SAVE_O(SAVE));
    ////////////////////////////////////////////////////////////////////////////
    // verdict
    task automatic test_done();
        $display("checks %0d bad %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] ex);
        n_tests++;
        if (got !== ex) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask : chk
    task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
        u_cpu.bus(w, a, d, rd);
        if (u_cpu.hung) begin
            bad_count++;
            test_done();
        end
    endtask : rw
    // bounded wait: s=0 save flag, else core reset
    task automatic wait_for(input int s, input logic lvl);
        n = 0;
        while ((s == 0 ? SAVE : CRST) !== lvl) begin
            @(posedge MCLK_I);
            n++;
            if (n > 400) begin
                bad_count++;
                test_done();
            end
        end
    endtask : wait_for
    // save entry; exit checks and clears cause
    task automatic enter_save(input logic [31:0] wk);
        rw(1'b1, pmw_pkg::ADDR_WAKE, wk);
        rw(1'b1, pmw_pkg::ADDR_CTRL, 32'h53);
        wait_for(0, 1'b1);
        chk({STBY, SOSC, CORE, IO, NVM, HB, MOSC, CRST}, 32'hC0);
    endtask : enter_save
    task automatic leave_save(input logic [31:0] cause);
        wait_for(0, 1'b0);
        wait_for(1, 1'b1);
        rw(1'b0, pmw_pkg::ADDR_STAT, 32'h0);
        chk(rd & 32'h7, cause);
        rw(1'b1, pmw_pkg::ADDR_STAT, 32'h7);
    endtask : leave_save
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{'{1'b0, pmw_pkg::ADDR_CTRL, 32'h0, 32'h2},
            '{1'b1, pmw_pkg::ADDR_CTRL, 32'h50, 32'h0},
            '{1'b0, pmw_pkg::ADDR_CTRL, 32'h0, 32'h50},
            '{1'b1, pmw_pkg::ADDR_WAKE, 32'hF, 32'h0},
            '{1'b0, pmw_pkg::ADDR_WAKE, 32'h0, 32'hF},
            '{1'b1, pmw_pkg::ADDR_TLOAD, 32'hFFFF, 32'h0},
            '{1'b0, pmw_pkg::ADDR_TLOAD, 32'h0, 32'hFFFF},
            '{1'b0, 8'h40, 32'h0, 32'h0},
            '{1'b0, pmw_pkg::ADDR_STAT, 32'h0, 32'h610}};
        repeat (4) @(posedge MCLK_I);
        RST_N_I <= 1'b1;
        wait_for(1, 1'b1);
        chk(SACT, 1);
        for (int i = 0; i < 9; i++) begin
            rw(rows[i].we, rows[i].adr, rows[i].wd);
            if (!rows[i].we) chk(rd, rows[i].ex);
        end
        chk({NVM, FDIV}, 32'h05);
        $display("regs done");
        for (k = 0; k < 2; k++) begin
            u_cpu.wait_instr(k);
            repeat (6) @(posedge MCLK_I);
            chk(CPUCK, 0);
            u_cpu.irq(1'b1);
            repeat (6) @(posedge MCLK_I);
            chk(CPUCK, 1);
            u_cpu.irq(1'b0);
        end
        $display("sleep done");
        rw(1'b1, pmw_pkg::ADDR_TLOAD, 32'h14);
        enter_save(32'h8);
        wait_for(0, 1'b0);
        chk(n >= 19 && n <= 23, 1);
        leave_save(32'h4);
        $display("timer done");
        FIELD_PRESENT_I <= 1'b1;
        enter_save(32'h2);
        repeat (40) @(posedge MCLK_I);
        chk({SAVE, NFC}, 32'h3);
        WAKE_PIN_I <= 1'b0;
        leave_save(32'h2);
        WAKE_PIN_I <= 1'b1;
        FIELD_PRESENT_I <= 1'b0;
        repeat (8) @(posedge MCLK_I);
        enter_save(32'h1);
        repeat (20) @(posedge MCLK_I);
        FIELD_PRESENT_I <= 1'b1;
        leave_save(32'h1);
        $display("wake done");
        RST_N_I <= 1'b0;
        SUPPLY_DETECT_I <= 1'b0;
        repeat (4) @(posedge MCLK_I);
        RST_N_I <= 1'b1;
        wait_for(1, 1'b1);
        chk(SACT, 0);
        for (k = 0; k < 2; k++) begin
            BRIDGE_SUPPLY_PIN_FULL_I <= k[0];
            repeat (6) @(posedge MCLK_I);
            n = 0;
            repeat (64) begin
                @(posedge MCLK_I);
                n += BCHG;
            end
            chk(n, k == 0 ? 16 : 0);
        end
        $display("passive done");
        test_done();
    end
endmodule : pmw_top_test
`default_nettype wire
